//--- rtl/rtcr_defs.vh
// constants for the rtc register bank: offsets, field positions, masks, defaults, timing
`ifndef RTCR_DEFS_VH
`define RTCR_DEFS_VH
// register offsets
`define RTCR_A_CTRL1 5'h00
`define RTCR_A_CTRL2 5'h01
`define RTCR_A_TRIM 5'h02
`define RTCR_A_SCRATCH 5'h03
`define RTCR_A_SEC 5'h04
`define RTCR_A_MIN 5'h05
`define RTCR_A_HOUR 5'h06
`define RTCR_A_DAY 5'h07
`define RTCR_A_WDAY 5'h08
`define RTCR_A_MON 5'h09
`define RTCR_A_YEAR 5'h0A
`define RTCR_A_ALM_SEC 5'h0B
`define RTCR_A_ALM_MIN 5'h0C
`define RTCR_A_ALM_HOUR 5'h0D
`define RTCR_A_ALM_DAY 5'h0E
`define RTCR_A_ALM_WDAY 5'h0F
`define RTCR_A_TVAL 5'h10
`define RTCR_A_TMODE 5'h11
`define RTCR_A_LAST 5'h11
// field positions
`define RTCR_B_STOP 5
`define RTCR_B_MODE12 1
`define RTCR_B_ALARM_FLAG 6
`define RTCR_B_CD_FLAG 3
`define RTCR_B_OSC_HALT 7
`define RTCR_B_PM 5
`define RTCR_B_MATCH_EN 7
`define RTCR_B_CD_EN 2
// implemented-bit masks; soft reset bit of ctrl1 left out so it reads zero
`define RTCR_M_CTRL1 8'hA7
`define RTCR_M_MIN 8'h7F
`define RTCR_M_HOUR 8'h3F
`define RTCR_M_WDAY 8'h07
`define RTCR_M_MON 8'h1F
`define RTCR_M_ALM_HD 8'hBF
`define RTCR_M_ALM_WDAY 8'h87
`define RTCR_M_TMODE 8'h1F
// reset values and commands
`define RTCR_D_SEC 8'h80
`define RTCR_D_ONE 8'h01
`define RTCR_SOFT_RST 8'h58
// timing
`define RTCR_CLK_HZ 250000000
`define RTCR_FAST_HZ 4096
`endif

//--- rtl/rtcr_i2c_slave.v
// two-wire serial slave: address match, byte shifting, acknowledge
`timescale 1ns/10ps
module rtcr_i2c_slave #(
  parameter [6:0] DEV_ADDR = 7'h2A
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // bus pins, asynchronous
  input wire scl_pin,
  input wire sda_pin,
  output reg sda_oe_q,
  // byte side toward the register bank
  input wire [7:0] rd_byte,
  output reg sel_q,
  output reg wr_stb_q,
  output reg wr_first_q,
  output reg [7:0] wr_byte_q,
  output reg rd_done_q
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK_A = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_ACK_W = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  reg [2:0] scl_s_q;
  reg [2:0] sda_s_q;
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg rw_q;
  reg first_q;
  wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
  wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
  wire start_c = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  wire stop_c = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

  // two-stage synchronisers; edge logic reads stage two and three only
  always @(posedge clk)
  begin
    if (reset)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_pin};
      sda_s_q <= {sda_s_q[1:0], sda_pin};
    end
  end

  // bit-level state machine; start and stop take priority over clock edges
  always @(posedge clk)
  begin
    wr_stb_q <= 1'b0;
    rd_done_q <= 1'b0;
    if (reset)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      sel_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_first_q <= 1'b0;
      wr_byte_q <= 8'h00;
    end
    else if (stop_c)
    begin
      st_q <= ST_IDLE;
      sel_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (start_c)
    begin
      st_q <= ST_ADDR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_q == ST_ADDR || st_q == ST_WDATA)
      begin
        sh_q <= {sh_q[6:0], sda_s_q[1]};
        cnt_q <= cnt_q + 4'h1;
      end
      else if (st_q == ST_RACK)
      begin
        rd_done_q <= 1'b1;
        st_q <= sda_s_q[1] ? ST_IDLE : ST_ACK_A;
      end
    end
    else if (scl_fall)
    begin
      case (st_q)
        ST_ADDR:
          if (cnt_q == 4'h8)
          begin
            if (sh_q[7:1] == DEV_ADDR)
            begin
              sel_q <= 1'b1;
              sda_oe_q <= 1'b1;
              rw_q <= sh_q[0];
              first_q <= 1'b1;
              st_q <= ST_ACK_A;
            end
            else
              st_q <= ST_IDLE;
          end
        ST_ACK_A:
          if (rw_q)
          begin
            // reload from the pointer, already advanced past the last byte
            sh_q <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            cnt_q <= 4'h1;
            st_q <= ST_RDATA;
          end
          else
          begin
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= ST_WDATA;
          end
        ST_WDATA:
          if (cnt_q == 4'h8)
          begin
            sda_oe_q <= 1'b1;
            wr_stb_q <= 1'b1;
            wr_byte_q <= sh_q;
            wr_first_q <= first_q;
            first_q <= 1'b0;
            st_q <= ST_ACK_W;
          end
        ST_ACK_W:
        begin
          sda_oe_q <= 1'b0;
          cnt_q <= 4'h0;
          st_q <= ST_WDATA;
        end
        ST_RDATA:
          if (cnt_q == 4'h8)
          begin
            sda_oe_q <= 1'b0;
            st_q <= ST_RACK;
          end
          else
          begin
            sda_oe_q <= ~sh_q[6];
            sh_q <= {sh_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        default:
          sda_oe_q <= 1'b0;
      endcase
    end
  end
endmodule

//--- rtl/rtcr_regbank.v
// rtc register bank: eighteen byte registers, bcd time chain, alarm and countdown
`timescale 1ns/10ps
`include "rtcr_defs.vh"

module rtcr_regbank #(
  parameter [6:0] DEV_ADDR = 7'h2A,
  parameter FAST_DIV = `RTCR_CLK_HZ / `RTCR_FAST_HZ
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // two-wire bus pins
  input wire scl_pin,
  input wire sda_pin,
  output reg sda_out_q,
  output wire sda_oe
);
  reg [7:0] rf_q [0:17];
  reg [4:0] ptr_q;
  reg [11:0] pre_q;
  reg pend_q;
  reg alm_chk_q;
  reg [7:0] cd_q;
  integer i;

  wire sel;
  wire wr_stb;
  wire wr_first;
  wire [7:0] wr_byte;
  wire rd_done;
  wire fast_tick;

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------

  // bit mask of implemented positions for each register
  function [7:0] mask_of;
    input [4:0] a;
    begin
      case (a)
        `RTCR_A_CTRL1: mask_of = `RTCR_M_CTRL1;
        `RTCR_A_MIN: mask_of = `RTCR_M_MIN;
        `RTCR_A_HOUR: mask_of = `RTCR_M_HOUR;
        `RTCR_A_DAY: mask_of = `RTCR_M_HOUR;
        `RTCR_A_WDAY: mask_of = `RTCR_M_WDAY;
        `RTCR_A_MON: mask_of = `RTCR_M_MON;
        `RTCR_A_ALM_HOUR: mask_of = `RTCR_M_ALM_HD;
        `RTCR_A_ALM_DAY: mask_of = `RTCR_M_ALM_HD;
        `RTCR_A_ALM_WDAY: mask_of = `RTCR_M_ALM_WDAY;
        `RTCR_A_TMODE: mask_of = `RTCR_M_TMODE;
        default: mask_of = 8'hFF;
      endcase
    end
  endfunction

  // power-on and soft-reset contents
  function [7:0] dflt_of;
    input [4:0] a;
    begin
      case (a)
        `RTCR_A_SEC: dflt_of = `RTCR_D_SEC;
        `RTCR_A_DAY: dflt_of = `RTCR_D_ONE;
        `RTCR_A_MON: dflt_of = `RTCR_D_ONE;
        default: dflt_of = 8'h00;
      endcase
    end
  endfunction

  // bcd increment with wrap; out-of-range values also wrap, so bad writes recover
  function [7:0] bcd_inc;
    input [7:0] v;
    input [7:0] top;
    input [7:0] bot;
    begin
      if (v >= top)
        bcd_inc = bot;
      else if (v[3:0] >= 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = v + 8'h01;
    end
  endfunction

  // last day of the month; leap years are the bcd multiples of four
  function [7:0] month_end;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[1:0] == 2'h2) : (yr[1:0] == 2'h0);
      case (mon)
        8'h02: month_end = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
        default: month_end = 8'h31;
      endcase
    end
  endfunction

  // pointer step with wrap after the last register
  function [4:0] ptr_step;
    input [4:0] p;
    begin
      ptr_step = (p >= `RTCR_A_LAST) ? `RTCR_A_CTRL1 : p + 5'h01;
    end
  endfunction

  // -----------------------------------------------------------------
  // sub-blocks
  // -----------------------------------------------------------------

  // bus slave; the frozen state lasts for the whole selected transaction
  rtcr_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clk(clk),
    .reset(reset),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .sda_oe_q(sda_oe),
    .rd_byte(rf_q[ptr_q] & mask_of(ptr_q)),
    .sel_q(sel),
    .wr_stb_q(wr_stb),
    .wr_first_q(wr_first),
    .wr_byte_q(wr_byte),
    .rd_done_q(rd_done)
  );

  // 4096 Hz base enable; every slower rate is counted down from it
  rtcr_tick_div #(
    .COUNT(FAST_DIV)
  ) u_div (
    .clk(clk),
    .reset(reset),
    .tick_q(fast_tick)
  );

  // -----------------------------------------------------------------
  // decode of control fields
  // -----------------------------------------------------------------

  wire stop_bit = rf_q[`RTCR_A_CTRL1][`RTCR_B_STOP];
  wire mode12 = rf_q[`RTCR_A_CTRL1][`RTCR_B_MODE12];
  wire wr_data = wr_stb & ~wr_first;
  wire soft_rst = wr_data && ptr_q == `RTCR_A_CTRL1 && wr_byte == `RTCR_SOFT_RST;
  wire tick64 = fast_tick && pre_q[5:0] == 6'h3F;
  wire sec_tick = fast_tick && pre_q == 12'hFFF && !stop_bit;
  wire adv = !sel && (sec_tick || pend_q);
  wire [1:0] src_sel = rf_q[`RTCR_A_TMODE][4:3];
  wire cd_en = rf_q[`RTCR_A_TMODE][`RTCR_B_CD_EN];

  // -----------------------------------------------------------------
  // bcd time chain, next values
  // -----------------------------------------------------------------

  reg [7:0] n_sec;
  reg [7:0] n_min;
  reg [7:0] n_hour;
  reg [7:0] n_day;
  reg [7:0] n_wday;
  reg [7:0] n_mon;
  reg [7:0] n_year;
  reg c_min;
  reg c_hour;
  reg c_day;
  reg c_mon;
  reg c_year;
  reg [7:0] inc_sec;
  reg [7:0] inc_hr12;

  // carry ripples seconds through years in one cycle; the chain is BCD throughout
  always @*
  begin
    inc_sec = bcd_inc({1'b0, rf_q[`RTCR_A_SEC][6:0]}, 8'h59, 8'h00);
    inc_hr12 = bcd_inc({3'h0, rf_q[`RTCR_A_HOUR][4:0]}, 8'h12, 8'h01);
    c_min = rf_q[`RTCR_A_SEC][6:0] >= 7'h59;
    n_sec = {rf_q[`RTCR_A_SEC][7], inc_sec[6:0]};
    c_hour = c_min && rf_q[`RTCR_A_MIN] >= 8'h59;
    n_min = c_min ? bcd_inc(rf_q[`RTCR_A_MIN], 8'h59, 8'h00) : rf_q[`RTCR_A_MIN];
    if (mode12)
    begin
      // 11 -> 12 flips the afternoon flag; 12 -> 1 keeps it
      c_day = c_hour && rf_q[`RTCR_A_HOUR][`RTCR_B_PM] && rf_q[`RTCR_A_HOUR][4:0] == 5'h11;
      n_hour = rf_q[`RTCR_A_HOUR];
      if (c_hour)
      begin
        n_hour[4:0] = inc_hr12[4:0];
        if (rf_q[`RTCR_A_HOUR][4:0] == 5'h11)
          n_hour[`RTCR_B_PM] = ~rf_q[`RTCR_A_HOUR][`RTCR_B_PM];
      end
    end
    else
    begin
      c_day = c_hour && rf_q[`RTCR_A_HOUR] >= 8'h23;
      n_hour = c_hour ? bcd_inc(rf_q[`RTCR_A_HOUR], 8'h23, 8'h00)
        : rf_q[`RTCR_A_HOUR];
    end
    c_mon = c_day && rf_q[`RTCR_A_DAY] >= month_end(rf_q[`RTCR_A_MON], rf_q[`RTCR_A_YEAR]);
    n_day = c_day ? bcd_inc(rf_q[`RTCR_A_DAY],
      month_end(rf_q[`RTCR_A_MON], rf_q[`RTCR_A_YEAR]), 8'h01) : rf_q[`RTCR_A_DAY];
    n_wday = c_day ? bcd_inc(rf_q[`RTCR_A_WDAY], 8'h06, 8'h00) : rf_q[`RTCR_A_WDAY];
    c_year = c_mon && rf_q[`RTCR_A_MON] >= 8'h12;
    n_mon = c_mon ? bcd_inc(rf_q[`RTCR_A_MON], 8'h12, 8'h01) : rf_q[`RTCR_A_MON];
    n_year = c_year ? bcd_inc(rf_q[`RTCR_A_YEAR], 8'h99, 8'h00) : rf_q[`RTCR_A_YEAR];
  end

  // -----------------------------------------------------------------
  // alarm and countdown events
  // -----------------------------------------------------------------

  wire [7:0] a_s = rf_q[`RTCR_A_ALM_SEC];
  wire [7:0] a_m = rf_q[`RTCR_A_ALM_MIN];
  wire [7:0] a_h = rf_q[`RTCR_A_ALM_HOUR];
  wire [7:0] a_d = rf_q[`RTCR_A_ALM_DAY];
  wire [7:0] a_w = rf_q[`RTCR_A_ALM_WDAY];
  wire any_en = a_s[7] | a_m[7] | a_h[7] | a_d[7] | a_w[7];
  // a field takes part only with its match enable set
  wire all_match = (!a_s[7] || a_s[6:0] == rf_q[`RTCR_A_SEC][6:0])
    && (!a_m[7] || a_m[6:0] == rf_q[`RTCR_A_MIN][6:0])
    && (!a_h[7] || a_h[5:0] == rf_q[`RTCR_A_HOUR][5:0])
    && (!a_d[7] || a_d[5:0] == rf_q[`RTCR_A_DAY][5:0])
    && (!a_w[7] || a_w[2:0] == rf_q[`RTCR_A_WDAY][2:0]);
  wire alarm_set = alm_chk_q && any_en && all_match;

  reg src_tick;

  // countdown source: 4096 Hz, 64 Hz, 1 Hz or once a minute
  always @*
  begin
    case (src_sel)
      2'h0: src_tick = fast_tick;
      2'h1: src_tick = tick64;
      2'h2: src_tick = sec_tick;
      default: src_tick = adv && c_min;
    endcase
  end

  wire cd_set = cd_en && src_tick && cd_q <= 8'h01;

  // -----------------------------------------------------------------
  // pointer, prescaler, freeze and countdown state
  // -----------------------------------------------------------------

  // pointer: first written byte loads it, each data byte after that steps it
  always @(posedge clk)
  begin
    if (reset)
      ptr_q <= `RTCR_A_CTRL1;
    else if (wr_stb && wr_first)
      ptr_q <= (wr_byte[4:0] > `RTCR_A_LAST || wr_byte[7:5] != 3'h0)
        ? `RTCR_A_CTRL1 : wr_byte[4:0];
    else if (wr_data || rd_done)
      ptr_q <= ptr_step(ptr_q);
  end

  // prescaler held at zero while stopped, so the first second is a full one
  always @(posedge clk)
  begin
    if (reset || stop_bit || soft_rst)
      pre_q <= 12'h000;
    else if (fast_tick)
      pre_q <= pre_q + 12'h001;
  end

  // one held-back second survives a freeze; longer holds lose further ticks
  always @(posedge clk)
  begin
    if (reset || soft_rst)
    begin
      pend_q <= 1'b0;
      alm_chk_q <= 1'b0;
    end
    else
    begin
      if (sel && sec_tick)
        pend_q <= 1'b1;
      else if (!sel)
        pend_q <= pend_q & sec_tick;
      alm_chk_q <= adv;
    end
  end

  // countdown counter; a write of the reload value restarts it
  always @(posedge clk)
  begin
    if (reset || soft_rst)
      cd_q <= 8'h00;
    else if (wr_data && ptr_q == `RTCR_A_TVAL)
      cd_q <= wr_byte;
    else if (cd_en && src_tick)
      cd_q <= (cd_q <= 8'h01) ? rf_q[`RTCR_A_TVAL] : cd_q - 8'h01;
  end

  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------

  // time advance and bus writes never meet: writes need the freeze
  always @(posedge clk)
  begin
    if (reset || soft_rst)
    begin
      for (i = 0; i <= `RTCR_A_LAST; i = i + 1)
        rf_q[i] <= dflt_of(i[4:0]);
    end
    else
    begin
      if (adv)
      begin
        rf_q[`RTCR_A_SEC] <= n_sec;
        rf_q[`RTCR_A_MIN] <= n_min;
        rf_q[`RTCR_A_HOUR] <= n_hour;
        rf_q[`RTCR_A_DAY] <= n_day;
        rf_q[`RTCR_A_WDAY] <= n_wday;
        rf_q[`RTCR_A_MON] <= n_mon;
        rf_q[`RTCR_A_YEAR] <= n_year;
      end
      if (wr_data)
      begin
        if (ptr_q == `RTCR_A_CTRL2)
          // flags clear on a written zero only; a one leaves them alone
          rf_q[ptr_q] <= wr_byte & {1'b1, rf_q[`RTCR_A_CTRL2][6], 2'h3,
            rf_q[`RTCR_A_CTRL2][3], 3'h7};
        else
          rf_q[ptr_q] <= wr_byte & mask_of(ptr_q);
      end
      // set placed last so an event wins over a clear in the same cycle
      if (alarm_set)
        rf_q[`RTCR_A_CTRL2][`RTCR_B_ALARM_FLAG] <= 1'b1;
      if (cd_set)
        rf_q[`RTCR_A_CTRL2][`RTCR_B_CD_FLAG] <= 1'b1;
    end
  end

  // open-drain data line: the driven level is always low
  always @(posedge clk)
  begin
    sda_out_q <= 1'b0;
  end
endmodule

//--- rtl/rtcr_tick_div.v
// clock divider making a one-cycle enable pulse
`timescale 1ns/10ps
module rtcr_tick_div #(
  parameter COUNT = 61035
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // enable pulse out
  output reg tick_q
);
  reg [31:0] cnt_q;

  // free-running count; one pulse per COUNT cycles
  always @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= COUNT - 1)
    begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end
endmodule

//--- sim/rtcr_host_model.sv
// two-wire bus host model with the open-drain data line resolved
`timescale 1ns/10ps
module rtcr_host_model #(
  parameter HALF = 313
) (
  // clock
  input wire clk,
  // device pull-down request
  input wire sda_oe,
  // bus lines
  output reg scl,
  output wire sda
);
  reg sda_drv;
  // wired-and with pull-up, a released line reads high
  assign sda = sda_drv & ~sda_oe;
  // both lines released from time zero
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // default half period keeps 400 kbit/s; a bench may shorten it
  task pause(input integer n);
  begin
    repeat (n) @(negedge clk);
  end
  endtask
  // one bit; data moves only while scl is low
  task clk_bit(input b, output s);
  begin
    sda_drv = b;
    pause(HALF);
    scl = 1'b1;
    pause(HALF);
    s = sda;
    scl = 1'b0;
    pause(4);
  end
  endtask
  // start, also used as repeated start
  task bus_start;
  begin
    sda_drv = 1'b1;
    pause(HALF);
    scl = 1'b1;
    pause(HALF);
    sda_drv = 1'b0;
    pause(HALF);
    scl = 1'b0;
    pause(4);
  end
  endtask
  task bus_stop;
  begin
    sda_drv = 1'b0;
    pause(HALF);
    scl = 1'b1;
    pause(HALF);
    sda_drv = 1'b1;
    pause(HALF);
  end
  endtask
  // byte out msb first, then the acknowledge sampled from the device
  task put_byte(input [7:0] v, output ack);
    integer i;
    reg s;
  begin
    for (i = 7; i >= 0; i = i - 1)
      clk_bit(v[i], s);
    clk_bit(1'b1, ack);
  end
  endtask
  // byte in msb first; the last one is not acknowledged
  task get_byte(output [7:0] v, input last);
    integer i;
    reg s;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      clk_bit(1'b1, s);
      v[i] = s;
    end
    clk_bit(last, s);
  end
  endtask
endmodule

//--- sim/rtcr_regbank_monitor.sv
// pin-level checker for the rtc register bank
`timescale 1ns/10ps
module rtcr_regbank_monitor (
  // clock and reset
  input wire clk,
  input wire reset,
  // bus pins
  input wire scl_pin,
  input wire sda_pin,
  input wire sda_out_q,
  input wire sda_oe
);
  // ---------------
  // helper counters
  // ---------------
  reg [7:0] hi_q;
  reg [8:0] oe_q;
  // saturating runs of scl high and of device drive
  always @(posedge clk)
  begin
    if (reset)
    begin
      hi_q <= 8'h00;
      oe_q <= 9'h000;
    end
    else
    begin
      hi_q <= !scl_pin ? 8'h00 : ((hi_q == 8'hFF) ? hi_q : hi_q + 8'h01);
      oe_q <= !sda_oe ? 9'h000 : ((oe_q == 9'h1FF) ? oe_q : oe_q + 9'h001);
    end
  end
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_out_low: assert property (sda_out_q == 1'b0)
    else $error("data output value not low");
  a_reset_quiet: assert property ($fell(reset) |-> !sda_oe)
    else $error("data driven right after reset");
  // the device moves data only after the synced scl fall
  a_rise_after_fall: assert property ($rose(sda_oe) |-> !scl_pin && ($past(scl_pin, 2)
    || $past(scl_pin, 3) || $past(scl_pin, 4) || $past(scl_pin, 5) || $past(scl_pin, 6)))
    else $error("drive began away from an scl fall");
  a_fall_after_fall: assert property ($fell(sda_oe) |-> !scl_pin && ($past(scl_pin, 2)
    || $past(scl_pin, 3) || $past(scl_pin, 4) || $past(scl_pin, 5) || $past(scl_pin, 6)))
    else $error("drive ended away from an scl fall");
  a_drive_holds: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("drive shorter than one bit");
  a_steady_high: assert property (scl_pin && $past(scl_pin) && $past(scl_pin, 2)
    && $past(scl_pin, 3) |-> $stable(sda_oe))
    else $error("data moved while scl high");
  a_idle_quiet: assert property (hi_q > 8'h18 |-> !sda_oe)
    else $error("data driven on idle bus");
  // an ack plus eight zero bits is the longest legal drive
  a_drive_bounded: assert property (oe_q < 9'h0E6)
    else $error("drive held too long");
  c_ack: cover property ($rose(sda_oe) ##1 sda_oe);
  c_long_drive: cover property (oe_q > 9'h0A0);
  c_idle: cover property (hi_q == 8'hFF);
endmodule
bind rtcr_regbank rtcr_regbank_monitor mon (.clk(clk), .reset(reset), .scl_pin(scl_pin),
  .sda_pin(sda_pin), .sda_out_q(sda_out_q), .sda_oe(sda_oe));

//--- sim/rtcr_regbank_test.sv
// self-checking bench for the rtc register bank
`timescale 1ns/10ps
`include "rtcr_defs.vh"
module rtcr_regbank_test;
  // ----------------------
  // clock, reset and parts
  // ----------------------
  localparam [6:0] ADDR = 7'h2A;
  localparam [55:0] SET_T = 56'h59_59_23_28_06_02_23;
  localparam [55:0] NEXT_T = 56'h00_00_00_01_00_03_23;
  reg clk = 1'b0;
  reg reset = 1'b1;
  wire scl;
  wire sda;
  wire sda_oe;
  wire sda_out_q;
  integer miscompares = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer i;
  reg [7:0] wbuf [0:18];
  reg [7:0] rbuf [0:17];
  reg a;
  always #2 clk = ~clk;
  // short prescaler: one second is 16384 clocks
  rtcr_regbank #(.DEV_ADDR(ADDR), .FAST_DIV(4)) dut (.clk(clk), .reset(reset),
    .scl_pin(scl), .sda_pin(sda), .sda_out_q(sda_out_q), .sda_oe(sda_oe));
  // fast bus so the run stays short; the slave needs only 8 clocks a phase
  rtcr_host_model #(.HALF(10)) host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task chk_byte(input [7:0] got, input [7:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected byte at %0t: %h vs %h", $time, got, exp);
    end
  end
  endtask
  task chk_bit(input got, input exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected ack at %0t: %h vs %h", $time, got, exp);
    end
  end
  endtask
  task close_out;
  begin
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // ------------------
  // transaction tasks
  // ------------------
  task open_write(input [7:0] ptr);
  begin
    host.bus_start;
    host.put_byte({ADDR, 1'b0}, a);
    chk_bit(a, 1'b0);
    host.put_byte(ptr, a);
    chk_bit(a, 1'b0);
  end
  endtask
  task xfer_write(input [7:0] ptr, input integer n);
    integer k;
  begin
    open_write(ptr);
    for (k = 0; k < n; k = k + 1)
    begin
      host.put_byte(wbuf[k], a);
      chk_bit(a, 1'b0);
    end
    host.bus_stop;
  end
  endtask
  // repeated start, then n bytes from the current pointer
  task read_on(input integer n);
    integer k;
  begin
    host.bus_start;
    host.put_byte({ADDR, 1'b1}, a);
    chk_bit(a, 1'b0);
    for (k = 0; k < n; k = k + 1)
      host.get_byte(rbuf[k], k == n - 1);
    host.bus_stop;
  end
  endtask
  function [7:0] mask_of(input integer r);
  begin
    case (r)
      1: mask_of = 8'hB7;
      5: mask_of = `RTCR_M_MIN;
      6: mask_of = `RTCR_M_HOUR;
      7: mask_of = 8'h3F;
      8: mask_of = `RTCR_M_WDAY;
      9: mask_of = `RTCR_M_MON;
      13, 14: mask_of = `RTCR_M_ALM_HD;
      15: mask_of = `RTCR_M_ALM_WDAY;
      17: mask_of = `RTCR_M_TMODE;
      default: mask_of = 8'hFF;
    endcase
  end
  endfunction
  // ---------
  // scenarios
  // ---------
  // reset contents of all eighteen places, and a foreign address left unanswered
  task t_defaults;
  begin
    host.bus_start;
    host.put_byte({ADDR ^ 7'h01, 1'b0}, a);
    chk_bit(a, 1'b1);
    host.bus_stop;
    open_write(8'h00);
    read_on(18);
    for (i = 0; i < 18; i = i + 1)
      chk_byte(rbuf[i], (i == 4) ? `RTCR_D_SEC : ((i == 7 || i == 9) ? 8'h01 : 8'h00));
  end
  endtask
  // pointer past the end lands on 00h; nineteenth byte wraps onto 00h again
  task t_wrap;
  begin
    for (i = 0; i < 18; i = i + 1)
      wbuf[i] = 8'hFF;
    wbuf[18] = 8'h20;
    xfer_write(8'h12, 19);
    open_write(8'h00);
    read_on(18);
    chk_byte(rbuf[0], 8'h20);
    for (i = 1; i < 18; i = i + 1)
      chk_byte(rbuf[i], mask_of(i));
  end
  endtask
  // soft reset restores the bank defaults, reads zero, and the pointer still moves on
  task t_soft_reset;
  begin
    wbuf[0] = `RTCR_SOFT_RST;
    wbuf[1] = 8'h5A;
    xfer_write(8'h00, 2);
    open_write(8'h00);
    read_on(5);
    chk_byte(rbuf[0], 8'h00);
    chk_byte(rbuf[1], 8'h12);
    chk_byte(rbuf[2], 8'h00);
    chk_byte(rbuf[3], 8'h00);
    chk_byte(rbuf[4], `RTCR_D_SEC);
  end
  endtask
  // a second falls inside an open transaction; it shows only after stop
  task t_time_carry;
  begin
    wbuf[0] = 8'h20;
    xfer_write(8'h00, 1);
    for (i = 0; i < 7; i = i + 1)
      wbuf[i] = SET_T[55 - 8 * i -: 8];
    xfer_write(8'h04, 7);
    wbuf[0] = 8'h00;
    xfer_write(8'h00, 1);
    open_write(8'h04);
    repeat (24000) @(negedge clk);
    read_on(1);
    chk_byte(rbuf[0], 8'h59);
    open_write(8'h04);
    read_on(7);
    for (i = 0; i < 7; i = i + 1)
      chk_byte(rbuf[i], NEXT_T[55 - 8 * i -: 8]);
  end
  endtask
  // second match and countdown underflow set their flags; ones keep them, zeros clear
  task t_flags;
  begin
    wbuf[0] = 8'h20;
    wbuf[1] = 8'h00;
    wbuf[2] = 8'h00;
    wbuf[3] = 8'hA5;
    wbuf[4] = 8'h00;
    xfer_write(8'h00, 5);
    wbuf[0] = 8'h81;
    for (i = 1; i < 5; i = i + 1)
      wbuf[i] = 8'h00;
    wbuf[5] = 8'h01;
    wbuf[6] = 8'h14;
    xfer_write(8'h0B, 7);
    wbuf[0] = 8'h00;
    xfer_write(8'h00, 1);
    // one full second after release, well before the next one
    repeat (17000) @(negedge clk);
    open_write(8'h01);
    read_on(4);
    chk_byte(rbuf[0], 8'h48);
    chk_bit(rbuf[0][`RTCR_B_CD_FLAG], 1'b1);
    chk_byte(rbuf[1], 8'h00);
    chk_byte(rbuf[2], 8'hA5);
    chk_byte(rbuf[3], 8'h01);
    wbuf[0] = 8'h48;
    xfer_write(8'h01, 1);
    open_write(8'h01);
    read_on(1);
    chk_byte(rbuf[0], 8'h48);
    wbuf[0] = 8'h00;
    xfer_write(8'h01, 1);
    open_write(8'h01);
    read_on(1);
    chk_byte(rbuf[0], 8'h00);
  end
  endtask
  // hang guard, well above the roughly 75k cycles the run needs
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 95000)
    begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_defaults;
    t_wrap;
    t_soft_reset;
    t_time_carry;
    t_flags;
    close_out;
  end
endmodule
